// ---- verilog/lookup_engine_regs.svh ----
// constants for the address lookup engine
`ifndef LOOKUP_ENGINE_REGS_SVH
`define LOOKUP_ENGINE_REGS_SVH
`define CLK_FREQ_HZ 20000000
`define AGING_PERIOD_S 200
`define AGE_TICK_CYCLES (`CLK_FREQ_HZ)
`define AGE_STAMP_LIMIT 8'hC8
`define CFG1_AGING_BIT 10
`define CFG2_LONG_FRAME_BIT 1
`define MIN_FRAME_BYTES 11'h040
`define MAX_FRAME_BYTES 11'h5EE
`define LONG_FRAME_BYTES 11'h600
`define ENTRY_COUNT 1024
`define PORT_HOST 2'h0
`endif

// ---- verilog/lookup_engine_pkg.sv ----
// types for the address lookup engine
package lookup_engine_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SCAN = 5'h02,
    ST_RESOLVE = 5'h04,
    ST_WRITE = 5'h08,
    ST_AGE = 5'h10
  } state_t;
endpackage

// ---- verilog/mac_address_lookup_engine.sv ----
// layer-2 address lookup, learning, aging and egress port resolution
`timescale 1ns/1ps
`include "lookup_engine_regs.svh"
module mac_address_lookup_engine #(
  parameter int ENTRIES = `ENTRY_COUNT,
  parameter int NPORTS = 3,
  parameter int TICK_CYCLES = `AGE_TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_frame_valid,
  input wire logic [47:0] i_dst_addr,
  input wire logic [47:0] i_src_addr,
  input wire logic [1:0] i_src_port,
  input wire logic [10:0] i_frame_len,
  input wire logic i_framing_err,
  input wire logic i_fcs_err,
  input wire logic i_align_err,
  input wire logic i_pause_frame,
  input wire logic [NPORTS-1:0] i_vlan_members,
  input wire logic i_static_hit,
  input wire logic [NPORTS-1:0] i_static_ports,
  input wire logic [NPORTS-1:0] i_stp_forwarding,
  input wire logic [NPORTS-1:0] i_igmp_ports,
  input wire logic i_igmp_frame,
  input wire logic [NPORTS-1:0] i_mirror_ports,
  input wire logic [NPORTS-1:0] i_port_vlan_mask,
  input wire logic [15:0] i_global_switch_config_one,
  input wire logic [15:0] i_global_switch_config_two,
  output logic o_busy,
  output logic o_result_valid,
  output logic [NPORTS-1:0] o_preliminary_forward_ports,
  output logic [NPORTS-1:0] o_final_forward_ports,
  output logic o_dropped,
  output logic o_pause_to_flow_ctrl,
  output logic [10:0] o_entry_count
);
  localparam int AW = $clog2(ENTRIES);
  localparam logic [AW-1:0] LAST = AW'(ENTRIES - 1);

  // table storage
  logic [47:0] mac_mem [ENTRIES];
  logic [1:0] port_mem [ENTRIES];
  logic [7:0] stamp_mem [ENTRIES];
  logic [ENTRIES-1:0] valid_ff;

  lookup_engine_pkg::state_t state_ff;
  logic [AW-1:0] idx_ff;
  logic [AW-1:0] age_idx_ff;
  logic sa_hit_ff, da_hit_ff;
  logic [AW-1:0] sa_idx_ff;
  logic [1:0] da_port_ff;
  logic [47:0] dst_ff, src_ff;
  logic [1:0] in_port_ff;
  logic good_ff, pause_ff;
  logic [7:0] now_ff;
  logic [31:0] tick_cnt_ff;
  logic [NPORTS-1:0] vlan_ff, stat_ports_ff, stp_ff, igmp_ff;
  logic [NPORTS-1:0] mir_ff, pvlan_ff;
  logic stat_hit_ff, igmp_frm_ff;
  logic free_found_ff;
  logic [AW-1:0] free_idx_ff;
  logic [10:0] count_ff;

  // one-hot port bit from a port number
  function automatic logic [NPORTS-1:0] port_bit(input logic [1:0] p);
    port_bit = NPORTS'(1) << p;
  endfunction

  logic aging_on;
  logic [10:0] max_len;
  logic len_ok, frame_ok;
  assign aging_on = i_global_switch_config_one[`CFG1_AGING_BIT];
  assign max_len = i_global_switch_config_two[`CFG2_LONG_FRAME_BIT] ?
                   `LONG_FRAME_BYTES : `MAX_FRAME_BYTES;
  assign len_ok = (i_frame_len >= `MIN_FRAME_BYTES) &&
                  (i_frame_len <= max_len);
  assign frame_ok = len_ok && !i_framing_err && !i_fcs_err &&
                    !i_align_err;

  // time base: one stamp tick per second
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tick_cnt_ff <= 32'h0;
      now_ff <= 8'h00;
    end else if (tick_cnt_ff >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 32'h0;
      now_ff <= now_ff + 8'h01;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end
  end

  // state machine
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_ff <= lookup_engine_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        lookup_engine_pkg::ST_IDLE: begin
          if (i_frame_valid) begin
            state_ff <= lookup_engine_pkg::ST_SCAN;
          end else begin
            state_ff <= lookup_engine_pkg::ST_AGE;
          end
        end
        lookup_engine_pkg::ST_SCAN: begin
          if (idx_ff == LAST) begin
            state_ff <= lookup_engine_pkg::ST_RESOLVE;
          end
        end
        lookup_engine_pkg::ST_RESOLVE: state_ff <= lookup_engine_pkg::ST_WRITE;
        lookup_engine_pkg::ST_WRITE: state_ff <= lookup_engine_pkg::ST_IDLE;
        lookup_engine_pkg::ST_AGE: state_ff <= lookup_engine_pkg::ST_IDLE;
        default: state_ff <= lookup_engine_pkg::ST_IDLE;
      endcase
    end
  end

  // frame capture on acceptance
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dst_ff <= 48'h0;
      src_ff <= 48'h0;
      in_port_ff <= 2'h0;
      good_ff <= 1'b0;
      pause_ff <= 1'b0;
      vlan_ff <= '0;
      stat_ports_ff <= '0;
      stp_ff <= '0;
      igmp_ff <= '0;
      mir_ff <= '0;
      pvlan_ff <= '0;
      stat_hit_ff <= 1'b0;
      igmp_frm_ff <= 1'b0;
    end else if (state_ff == lookup_engine_pkg::ST_IDLE && i_frame_valid) begin
      dst_ff <= i_dst_addr;
      src_ff <= i_src_addr;
      in_port_ff <= i_src_port;
      good_ff <= frame_ok;
      pause_ff <= i_pause_frame;
      vlan_ff <= i_vlan_members;
      stat_ports_ff <= i_static_ports;
      stp_ff <= i_stp_forwarding;
      igmp_ff <= i_igmp_ports;
      mir_ff <= i_mirror_ports;
      pvlan_ff <= i_port_vlan_mask;
      stat_hit_ff <= i_static_hit;
      igmp_frm_ff <= i_igmp_frame;
    end
  end

  // sequential search of source and destination, one entry per cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      idx_ff <= '0;
      sa_hit_ff <= 1'b0;
      da_hit_ff <= 1'b0;
      sa_idx_ff <= '0;
      da_port_ff <= 2'h0;
      free_found_ff <= 1'b0;
      free_idx_ff <= '0;
    end else if (state_ff == lookup_engine_pkg::ST_IDLE) begin
      idx_ff <= '0;
      sa_hit_ff <= 1'b0;
      da_hit_ff <= 1'b0;
      free_found_ff <= 1'b0;
      free_idx_ff <= LAST;
    end else if (state_ff == lookup_engine_pkg::ST_SCAN) begin
      idx_ff <= idx_ff + AW'(1);
      if (valid_ff[idx_ff] && mac_mem[idx_ff] == src_ff) begin
        sa_hit_ff <= 1'b1;
        sa_idx_ff <= idx_ff;
      end
      if (valid_ff[idx_ff] && mac_mem[idx_ff] == dst_ff) begin
        da_hit_ff <= 1'b1;
        da_port_ff <= port_mem[idx_ff];
      end
      if (!valid_ff[idx_ff] && !free_found_ff) begin
        free_found_ff <= 1'b1;
        free_idx_ff <= idx_ff;
      end
    end
  end

  // stage one and two port resolution
  logic [NPORTS-1:0] prelim, final_set;
  logic is_local;
  always_comb begin
    if (stat_hit_ff) begin
      prelim = stat_ports_ff & vlan_ff;
    end else if (da_hit_ff) begin
      prelim = port_bit(da_port_ff) & vlan_ff;
    end else begin
      prelim = vlan_ff & ~port_bit(in_port_ff);
    end
    is_local = !stat_hit_ff && da_hit_ff &&
               (da_port_ff == in_port_ff);
    final_set = prelim & stp_ff;
    if (igmp_frm_ff) begin
      final_set = final_set & igmp_ff;
    end
    final_set = (final_set | mir_ff) & pvlan_ff & ~port_bit(in_port_ff);
    if (!good_ff || pause_ff || is_local) begin
      final_set = '0;
    end
  end

  // result outputs
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_result_valid <= 1'b0;
      o_preliminary_forward_ports <= '0;
      o_final_forward_ports <= '0;
      o_dropped <= 1'b0;
      o_pause_to_flow_ctrl <= 1'b0;
    end else begin
      o_result_valid <= (state_ff == lookup_engine_pkg::ST_RESOLVE);
      o_pause_to_flow_ctrl <= (state_ff == lookup_engine_pkg::ST_RESOLVE) &&
                              pause_ff && good_ff;
      if (state_ff == lookup_engine_pkg::ST_RESOLVE) begin
        o_preliminary_forward_ports <= prelim;
        o_final_forward_ports <= final_set;
        o_dropped <= (final_set == '0);
      end
    end
  end

  // busy flag: low exactly while the state is idle and can take a frame
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= !(state_ff == lookup_engine_pkg::ST_WRITE ||
                  state_ff == lookup_engine_pkg::ST_AGE);
    end
  end

  // single-write table update: learn, migrate, refresh
  logic [AW-1:0] wr_idx;
  logic do_learn, do_update, age_stale;
  assign wr_idx = free_found_ff ? free_idx_ff : LAST;
  assign do_learn = good_ff && !sa_hit_ff;
  assign do_update = sa_hit_ff;
  assign age_stale = aging_on && valid_ff[age_idx_ff] &&
                     ((now_ff - stamp_mem[age_idx_ff]) >=
                      `AGE_STAMP_LIMIT);

  always_ff @(posedge i_clock) begin
    if (state_ff == lookup_engine_pkg::ST_WRITE && do_learn) begin
      mac_mem[wr_idx] <= src_ff;
      port_mem[wr_idx] <= in_port_ff;
      stamp_mem[wr_idx] <= now_ff;
    end else if (state_ff == lookup_engine_pkg::ST_WRITE && do_update) begin
      stamp_mem[sa_idx_ff] <= now_ff;
      if (good_ff) begin
        port_mem[sa_idx_ff] <= in_port_ff;
      end
    end
  end

  // valid bits, aging walk and occupancy
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      valid_ff <= '0;
      age_idx_ff <= '0;
      count_ff <= 11'h000;
    end else if (state_ff == lookup_engine_pkg::ST_WRITE && do_learn) begin
      valid_ff[wr_idx] <= 1'b1;
      if (free_found_ff) begin
        count_ff <= count_ff + 11'h001;
      end
    end else if (state_ff == lookup_engine_pkg::ST_AGE) begin
      age_idx_ff <= age_idx_ff + AW'(1);
      if (age_stale) begin
        valid_ff[age_idx_ff] <= 1'b0;
        count_ff <= count_ff - 11'h001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_entry_count <= 11'h000;
    end else begin
      o_entry_count <= count_ff;
    end
  end

  // checks
  bad_no_fwd_a: assert property (@(posedge i_clock) disable iff (i_rst)
    state_ff == lookup_engine_pkg::ST_RESOLVE && !good_ff
    |=> o_final_forward_ports == '0) else $error("bad frame forwarded");
  pause_no_fwd_a: assert property (@(posedge i_clock) disable iff (i_rst)
    state_ff == lookup_engine_pkg::ST_RESOLVE && pause_ff
    |=> o_dropped) else $error("pause forwarded");
  local_drop_a: assert property (@(posedge i_clock) disable iff (i_rst)
    state_ff == lookup_engine_pkg::ST_RESOLVE && is_local
    |=> o_dropped) else $error("local frame forwarded");
  miss_flood_a: assert property (@(posedge i_clock) disable iff (i_rst)
    state_ff == lookup_engine_pkg::ST_RESOLVE && !da_hit_ff && !stat_hit_ff
    |=> o_preliminary_forward_ports == $past(vlan_ff & ~port_bit(in_port_ff)))
    else $error("miss flood wrong");
  learn_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    state_ff == lookup_engine_pkg::ST_WRITE && do_learn
    |=> valid_ff[$past(wr_idx)]) else $error("entry not learned");
  no_learn_bad_a: assert property (@(posedge i_clock) disable iff (i_rst)
    state_ff == lookup_engine_pkg::ST_WRITE && !good_ff |-> !do_learn)
    else $error("bad frame learned");
  aging_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !aging_on && state_ff != lookup_engine_pkg::ST_WRITE
    |=> $past(count_ff) <= count_ff) else $error("aged when off");
  final_subset_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_result_valid |-> (o_final_forward_ports & ~$past(pvlan_ff)) == '0)
    else $error("port vlan ignored");
  learn_c: cover property (@(posedge i_clock)
    state_ff == lookup_engine_pkg::ST_WRITE && do_learn);
  migrate_c: cover property (@(posedge i_clock)
    state_ff == lookup_engine_pkg::ST_WRITE && sa_hit_ff && good_ff);
  age_c: cover property (@(posedge i_clock)
    state_ff == lookup_engine_pkg::ST_AGE && age_stale);
endmodule

// ---- sim/ingress_port_model.sv ----
// ingress mac port model presenting received frames to the engine
`timescale 1ns/1ps
module ingress_port_model (
  input wire logic i_clock,
  input wire logic i_busy,
  output logic o_frame_valid,
  output logic [47:0] o_dst_addr,
  output logic [47:0] o_src_addr,
  output logic [1:0] o_src_port,
  output logic [10:0] o_frame_len,
  output logic [3:0] o_status
);
  // quiet lines at start; status is framing, fcs, align, pause
  initial begin
    o_frame_valid = 1'b0;
    o_dst_addr = 48'h0;
    o_src_addr = 48'h0;
    o_src_port = 2'h0;
    o_frame_len = 11'h0;
    o_status = 4'h0;
  end
  // one frame once the engine is idle, then lines show junk
  task automatic send(input logic [47:0] d, input logic [47:0] s,
      input logic [1:0] p, input logic [10:0] l, input logic [3:0] st);
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (i_busy !== 1'b0 && n < 2000);
    o_frame_valid = 1'b1;
    o_dst_addr = d;
    o_src_addr = s;
    o_src_port = p;
    o_frame_len = l;
    o_status = st;
    @(posedge i_clock);
    #1;
    o_frame_valid = 1'b0;
    o_dst_addr = ~d; // stale frame never repeats
    o_src_addr = ~s;
    o_frame_len = ~l;
    o_status = ~st;
  endtask
endmodule

// ---- sim/test_mac_address_lookup_engine.sv ----
// self-checking bench for the address lookup engine
`timescale 1ns/1ps
module test_mac_address_lookup_engine;
  logic i_clock, i_rst, fv, hit, igmp_fr, busy, rv, drop, pause;
  logic [47:0] da, sa;
  logic [1:0] sp;
  logic [10:0] len, cnt;
  logic [3:0] st;
  logic [2:0] sports, vlan, stp, igmp, mirror, pmask, pre, fin;
  logic [2:0] g_pre, g_fin;
  logic [15:0] cfg1, cfg2;
  logic g_drop, g_pause;
  int fail_count, comparisons;
  localparam logic [47:0] A1 = 48'h0200_0000_0001;
  localparam logic [47:0] A2 = 48'h0200_0000_0002;
  localparam logic [47:0] D0 = 48'h0200_0000_00D0;

  ingress_port_model u_ingress_port_model (.i_clock(i_clock),
    .i_busy(busy), .o_frame_valid(fv), .o_dst_addr(da),
    .o_src_addr(sa), .o_src_port(sp), .o_frame_len(len), .o_status(st));

  mac_address_lookup_engine #(.ENTRIES(4), .NPORTS(3), .TICK_CYCLES(10))
    u_mac_address_lookup_engine (.i_clock(i_clock), .i_rst(i_rst),
    .i_frame_valid(fv), .i_dst_addr(da), .i_src_addr(sa), .i_src_port(sp),
    .i_frame_len(len), .i_framing_err(st[0]), .i_fcs_err(st[1]),
    .i_align_err(st[2]), .i_pause_frame(st[3]), .i_vlan_members(vlan),
    .i_static_hit(hit), .i_static_ports(sports), .i_stp_forwarding(stp),
    .i_igmp_ports(igmp), .i_igmp_frame(igmp_fr), .i_mirror_ports(mirror),
    .i_port_vlan_mask(pmask), .i_global_switch_config_one(cfg1),
    .i_global_switch_config_two(cfg2), .o_busy(busy), .o_result_valid(rv),
    .o_preliminary_forward_ports(pre), .o_final_forward_ports(fin),
    .o_dropped(drop), .o_pause_to_flow_ctrl(pause), .o_entry_count(cnt));

  // 20 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_num(input logic [10:0] a, input logic [10:0] e);
    comparisons++;
    if (a !== e) begin
      $display("Error at %0t: got %h expected %h", $time, a, e);
      fail_count++;
    end
  endtask

  task automatic check_ports(input logic [2:0] a, input logic [2:0] e);
    comparisons++;
    if (a !== e) begin
      $display("Error at %0t: ports %h expected %h", $time, a, e);
      fail_count++;
    end
  endtask

  // send one frame, catch the one-cycle result, let the table write land
  task automatic frame(input logic [47:0] d, input logic [47:0] s,
      input logic [1:0] p, input logic [10:0] l, input logic [3:0] f);
    int n;
    u_ingress_port_model.send(d, s, p, l, f);
    n = 0;
    while (rv !== 1'b1) begin
      @(posedge i_clock);
      #1;
      n++;
      if (n > 40) begin
        fail_count++;
        complete_run();
      end
    end
    g_pre = pre;
    g_fin = fin;
    g_drop = drop;
    g_pause = pause;
    // entry count output trails the table write by one cycle
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  task automatic test_learn_flood();
    frame(D0, A1, 2'h1, 11'h040, 4'h0);
    check_ports(g_pre, 3'h5);
    check_ports(g_fin, 3'h5);
    check_num(g_drop, 11'h0);
    check_num(g_pause, 11'h0);
    check_num(cnt, 11'h001);
    frame(A1, A2, 2'h2, 11'h5EE, 4'h0);
    check_ports(g_pre, 3'h2);
    check_num(cnt, 11'h002);
  endtask

  task automatic test_errors();
    for (int i = 0; i < 5; i++) begin
      frame(D0, 48'h0300_0000_0000 + i, 2'h1,
        (i == 3) ? 11'h03F : (i == 4) ? 11'h5EF : 11'h040,
        (i < 3) ? (4'h1 << i) : 4'h0);
      check_num(g_drop, 11'h1);
      check_num(cnt, 11'h002);
    end
    cfg2 = 16'h0002;
    frame(D0, 48'h0400_0000_0005, 2'h1, 11'h600, 4'h0);
    check_num(g_drop, 11'h0);
    check_num(cnt, 11'h003);
    cfg2 = 16'h0000;
  endtask

  task automatic test_pause_local();
    frame(D0, A1, 2'h1, 11'h040, 4'h8);
    check_num(g_pause, 11'h1);
    check_num(g_drop, 11'h1);
    hit = 1'b1;
    sports = 3'h2;
    frame(D0, A1, 2'h1, 11'h040, 4'h0);
    check_num(g_drop, 11'h1);
    hit = 1'b0;
    sports = 3'h0;
    // dynamic entry points back at the ingress port
    frame(A1, A1, 2'h1, 11'h040, 4'h0);
    check_ports(g_pre, 3'h2);
    check_num(g_drop, 11'h1);
  endtask

  // second stage: stp, igmp, mirror and port vlan applied in turn
  task automatic test_stage_two();
    stp = 3'h5;
    igmp_fr = 1'b1;
    igmp = 3'h3;
    mirror = 3'h2;
    frame(D0, A2, 2'h0, 11'h040, 4'h0);
    check_ports(g_pre, 3'h6);
    check_ports(g_fin, 3'h2);
    check_num(g_drop, 11'h0);
    pmask = 3'h5;
    frame(D0, A2, 2'h0, 11'h040, 4'h0);
    check_ports(g_fin, 3'h0);
    check_num(g_drop, 11'h1);
    stp = 3'h7;
    igmp_fr = 1'b0;
    igmp = 3'h0;
    mirror = 3'h0;
    pmask = 3'h7;
  endtask

  task automatic test_migrate();
    frame(D0, A1, 2'h2, 11'h040, 4'h0);
    frame(A1, A2, 2'h0, 11'h040, 4'h0);
    check_ports(g_pre, 3'h4);
    check_num(cnt, 11'h003);
  endtask

  task automatic test_full();
    frame(D0, 48'hFFFF_FFFF_FFFE, 2'h1, 11'h040, 4'h0);
    check_num(cnt, 11'h004);
    frame(D0, 48'h0000_0000_0000, 2'h1, 11'h040, 4'h0);
    check_num(cnt, 11'h004);
    frame(48'h0, A2, 2'h0, 11'h040, 4'h0);
    check_ports(g_pre, 3'h2);
  endtask

  // stamp limit is 200 ticks of 10 cycles each
  task automatic test_aging();
    repeat (2600) @(posedge i_clock);
    #1;
    check_num(cnt, 11'h004);
    cfg1 = 16'h0400;
    repeat (2600) @(posedge i_clock);
    #1;
    check_num(cnt, 11'h000);
  endtask

  // reset, then the scenarios in turn
  initial begin
    fail_count = 0;
    comparisons = 0;
    i_rst = 1'b1;
    hit = 1'b0;
    igmp_fr = 1'b0;
    sports = 3'h0;
    vlan = 3'h7;
    stp = 3'h7;
    igmp = 3'h0;
    mirror = 3'h0;
    pmask = 3'h7;
    cfg1 = 16'h0000;
    cfg2 = 16'h0000;
    repeat (2) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    check_num(cnt, 11'h000);
    test_learn_flood();
    test_errors();
    test_pause_local();
    test_migrate();
    test_full();
    test_stage_two();
    test_aging();
    complete_run();
  end
endmodule
